// File: common/exec_pkg.sv
// Shared constants and carrier types for the five-instruction execution unit.
// Assumes a core that feeds opcode bytes in and owns the register file and memories.
package exec_pkg;
	// Opcodes
	localparam logic [7:0] op_bit_xor = 8'h27;
	localparam logic [7:0] op_call_direct = 8'hf6;
	localparam logic [7:0] op_call_pair = 8'hf4;
	localparam logic [7:0] op_call_vector = 8'hd4;
	localparam logic [7:0] op_carry_invert = 8'hef;
	localparam logic [7:0] op_zero_dest_reg = 8'hb0;
	localparam logic [7:0] op_zero_dest_ind = 8'hb1;
	localparam logic [7:0] op_complement_reg = 8'h60;
	localparam logic [7:0] op_complement_ind = 8'h61;
	// Flag register and bit positions
	localparam logic [7:0] status_flag_byte_addr = 8'hd5;
	localparam int flag_c = 7;
	localparam int flag_z = 6;
	localparam int flag_s = 5;
	localparam int flag_v = 4;
	localparam int flag_d = 3;
	localparam int flag_h = 2;
	localparam logic [7:0] status_flag_reset = 8'h00;
	localparam logic [15:0] stack_pointer_reset = 16'h0000;
	localparam logic [15:0] pc_reset = 16'h0000;
	// Working registers sit in bank 0c0h..0cfh
	localparam logic [3:0] working_bank = 4'hc;
	// Cycle counts per instruction
	localparam logic [4:0] cycles_bit_xor = 5'd10;
	localparam logic [4:0] cycles_call_direct = 5'd18;
	localparam logic [4:0] cycles_call_pair = 5'd18;
	localparam logic [4:0] cycles_call_vector = 5'd20;
	localparam logic [4:0] cycles_short = 5'd6;
	// Register file access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;
	// Memory access (program read or stack write)
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_type;
	typedef enum logic [3:0] {
		st_idle = 4'b0000,
		st_fetch1 = 4'b0001,
		st_fetch2 = 4'b0011,
		st_read_a = 4'b0010,
		st_read_b = 4'b0110,
		st_compute = 4'b0111,
		st_push_low = 4'b0101,
		st_push_high = 4'b0100,
		st_vec_high = 4'b1100,
		st_vec_low = 4'b1101,
		st_wait = 4'b1111
	} state_type;
endpackage

// File: verilog/bit_xor_unit.sv
// Single-bit exclusive-OR merge for the bit instruction.
// Assumes operands already fetched; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module bit_xor_unit (
	// Operands
	input wire logic [7:0] dst_value,
	input wire logic [7:0] src_value,
	input wire logic [2:0] bit_sel,
	input wire logic to_selected,
	// Result
	output logic [7:0] result
);
	logic picked;
	always_comb begin
		result = dst_value;
		if (to_selected) begin
			picked = dst_value[bit_sel] ^ src_value[0];
			result[bit_sel] = picked;
		end else begin
			picked = dst_value[0] ^ src_value[bit_sel];
			result[0] = picked;
		end
	end
endmodule
`default_nettype wire

// File: verilog/flag_update.sv
// Flag byte update for the bit-xor, complement and carry-invert operations.
// Assumes the result byte and old flags are valid in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module flag_update (
	// Inputs
	input wire logic [7:0] old_flags,
	input wire logic [7:0] result,
	input wire logic [1:0] kind,
	// Output
	output logic [7:0] new_flags
);
	always_comb begin
		new_flags = old_flags;
		unique case (kind)
			2'h1: begin
				new_flags[exec_pkg::flag_z] = (result == 8'h00);
				new_flags[exec_pkg::flag_s] = 1'b0;
			end
			2'h2: begin
				new_flags[exec_pkg::flag_z] = (result == 8'h00);
				new_flags[exec_pkg::flag_s] = result[7];
				new_flags[exec_pkg::flag_v] = 1'b0;
			end
			2'h3: new_flags[exec_pkg::flag_c] = ~old_flags[exec_pkg::flag_c];
			2'h0: new_flags = old_flags;
		endcase
	end
endmodule
`default_nettype wire

// File: verilog/exec_core.sv
// Execution sequencer for bit-xor, call, carry-invert, clear and complement.
// Assumes the register file and memories answer a read while the request stands.
// What this block does
// RULE1: Bit-xor merges selected bit with bit zero of the other operand.
// RULE2: Bit-xor changes only the target bit; the source stays untouched.
// RULE3: Bit-xor sets zero on zero result, clears sign, keeps carry, D, H.
// RULE4: Bit-xor is three bytes, ten cycles; second byte holds reg, bit, selector.
// RULE5: Call pushes low byte at sp-1, then high byte at sp-2.
// RULE6: Saved return address is the address after the call's last byte.
// RULE7: Call loads pc with target; direct 18, pair 18, vector 20 cycles.
// RULE8: Vector call reads target high byte then low byte from program memory.
// RULE9: Carry-invert toggles carry only, one byte, six cycles.
// RULE10: Carry lives in the flag byte at register address 0d5h.
// RULE11: Clear writes zero without touching flags; two bytes, six cycles.
// RULE12: Indirect forms write the register the pointer names; pointer kept.
// RULE13: Complement inverts the destination; two bytes, six cycles.
// RULE14: Complement sets zero and sign from result, clears overflow.
// RULE15: Undefined flags keep their previous value.
// RULE16: The target is fetched before both stack bytes are written.
`timescale 1ns/1ps
`default_nettype none
module exec_core (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Instruction start
	input wire logic start,
	input wire logic [7:0] opcode,
	// Register file
	output exec_pkg::reg_req_type reg_req,
	input wire logic [7:0] reg_rdata,
	// Program memory read / stack write
	output exec_pkg::mem_req_type prog_req,
	output exec_pkg::mem_req_type stack_req,
	input wire logic [7:0] prog_rdata,
	// Software register port
	input wire logic [7:0] sw_addr,
	input wire logic [7:0] sw_wdata,
	input wire logic sw_write,
	input wire logic sw_read,
	output logic [7:0] sw_rdata,
	// Status
	output logic busy,
	output logic done,
	output logic [15:0] pc,
	output logic [15:0] stack_pointer
);
	typedef struct packed {
		exec_pkg::state_type state;
		logic [7:0] op;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [7:0] val_a;
		logic [7:0] val_b;
		logic [7:0] target_addr;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] ret_addr;
		logic [15:0] target;
		logic [7:0] flags;
		logic [4:0] count;
		logic [4:0] total;
		logic done;
		logic [7:0] sw_rdata;
		exec_pkg::reg_req_type reg_req;
		exec_pkg::mem_req_type prog_req;
		exec_pkg::mem_req_type stack_req;
	} core_state_type;

	core_state_type cur;
	core_state_type next_cur;
	logic [7:0] xor_result;
	logic [7:0] flag_next;
	logic [1:0] flag_kind;

	function automatic logic [7:0] working_addr(input logic [3:0] n);
		working_addr = {exec_pkg::working_bank, n};
	endfunction

	function automatic logic [4:0] cycles_of(input logic [7:0] op);
		unique case (op)
			exec_pkg::op_bit_xor: cycles_of = exec_pkg::cycles_bit_xor;
			exec_pkg::op_call_direct: cycles_of = exec_pkg::cycles_call_direct;
			exec_pkg::op_call_pair: cycles_of = exec_pkg::cycles_call_pair;
			exec_pkg::op_call_vector: cycles_of = exec_pkg::cycles_call_vector;
			default: cycles_of = exec_pkg::cycles_short;
		endcase
	endfunction

	function automatic logic is_indirect(input logic [7:0] op);
		is_indirect = (op == exec_pkg::op_zero_dest_ind) || (op == exec_pkg::op_complement_ind);
	endfunction

	// Selector 1: the named register bit is the destination
	bit_xor_unit u_bit_xor (
		.dst_value(cur.val_a),
		.src_value(cur.val_b),
		.bit_sel(cur.byte1[3:1]),
		.to_selected(cur.byte1[0]),
		.result(xor_result)
	);

	flag_update u_flags (
		.old_flags(cur.flags),
		.result(cur.op == exec_pkg::op_bit_xor ? xor_result : ~cur.val_a),
		.kind(flag_kind),
		.new_flags(flag_next)
	);

	always_comb begin
		unique case (cur.op)
			exec_pkg::op_bit_xor: flag_kind = 2'h1;
			exec_pkg::op_complement_reg, exec_pkg::op_complement_ind: flag_kind = 2'h2;
			exec_pkg::op_carry_invert: flag_kind = 2'h3;
			default: flag_kind = 2'h0;
		endcase
	end

	always_comb begin
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.reg_req = '0;
		next_cur.prog_req = '0;
		next_cur.stack_req = '0;
		next_cur.sw_rdata = 8'h00;
		if (cur.state != exec_pkg::st_idle) begin
			next_cur.count = cur.count + 5'd1;
		end
		if (sw_read) begin
			next_cur.sw_rdata = (sw_addr == exec_pkg::status_flag_byte_addr) ? cur.flags : 8'h00; // see RULE10
		end
		if (sw_write && sw_addr == exec_pkg::status_flag_byte_addr) begin
			next_cur.flags = sw_wdata;
		end
		unique case (cur.state)
			exec_pkg::st_idle: begin
				if (start) begin
					next_cur.op = opcode;
					next_cur.count = 5'd1;
					next_cur.total = cycles_of(opcode); // see RULE4
					if (opcode == exec_pkg::op_carry_invert) begin
						next_cur.pc = cur.pc + 16'd1;
						next_cur.state = exec_pkg::st_compute;
					end else begin
						next_cur.prog_req.rd = 1'b1;
						next_cur.prog_req.addr = cur.pc + 16'd1;
						next_cur.state = exec_pkg::st_fetch1;
					end
				end
			end
			exec_pkg::st_fetch1: begin
				next_cur.byte1 = prog_rdata;
				if (cur.op == exec_pkg::op_bit_xor || cur.op == exec_pkg::op_call_direct) begin
					next_cur.prog_req.rd = 1'b1;
					next_cur.prog_req.addr = cur.pc + 16'd2;
					next_cur.state = exec_pkg::st_fetch2;
				end else if (cur.op == exec_pkg::op_call_vector) begin
					next_cur.ret_addr = cur.pc + 16'd2; // see RULE6
					next_cur.prog_req.rd = 1'b1;
					next_cur.prog_req.addr = {8'h00, prog_rdata}; // see RULE8
					next_cur.state = exec_pkg::st_vec_high;
				end else if (cur.op == exec_pkg::op_call_pair) begin
					next_cur.ret_addr = cur.pc + 16'd2; // see RULE6
					next_cur.reg_req.rd = 1'b1;
					next_cur.reg_req.addr = prog_rdata;
					next_cur.state = exec_pkg::st_read_a;
				end else begin
					next_cur.reg_req.rd = 1'b1;
					next_cur.reg_req.addr = prog_rdata;
					next_cur.target_addr = prog_rdata;
					next_cur.state = exec_pkg::st_read_a;
				end
			end
			exec_pkg::st_fetch2: begin
				next_cur.byte2 = prog_rdata;
				if (cur.op == exec_pkg::op_call_direct) begin
					next_cur.ret_addr = cur.pc + 16'd3; // see RULE6
					next_cur.target = {cur.byte1, prog_rdata};
					next_cur.state = exec_pkg::st_push_low;
				end else begin
					// Working-register nibble first, full register second
					next_cur.reg_req.rd = 1'b1;
					next_cur.reg_req.addr = working_addr(cur.byte1[7:4]);
					next_cur.state = exec_pkg::st_read_a;
				end
			end
			exec_pkg::st_read_a: begin
				if (cur.op == exec_pkg::op_bit_xor) begin
					next_cur.reg_req.rd = 1'b1;
					next_cur.reg_req.addr = cur.byte2;
					if (cur.byte1[0]) begin
						next_cur.val_b = reg_rdata;
					end else begin
						next_cur.val_a = reg_rdata;
					end
					next_cur.state = exec_pkg::st_read_b;
				end else if (cur.op == exec_pkg::op_call_pair) begin
					next_cur.target[15:8] = reg_rdata;
					next_cur.reg_req.rd = 1'b1;
					next_cur.reg_req.addr = cur.byte1 + 8'd1;
					next_cur.state = exec_pkg::st_read_b;
				end else if (is_indirect(cur.op)) begin
					// Pointer content names the real target; pointer is only read
					next_cur.target_addr = reg_rdata; // see RULE12
					next_cur.reg_req.rd = 1'b1;
					next_cur.reg_req.addr = reg_rdata;
					next_cur.op = (cur.op == exec_pkg::op_zero_dest_ind) ?
						exec_pkg::op_zero_dest_reg : exec_pkg::op_complement_reg;
				end else begin
					next_cur.val_a = reg_rdata;
					next_cur.state = exec_pkg::st_compute;
				end
			end
			exec_pkg::st_read_b: begin
				if (cur.op == exec_pkg::op_call_pair) begin
					next_cur.target[7:0] = reg_rdata;
					next_cur.state = exec_pkg::st_push_low;
				end else begin
					if (cur.byte1[0]) begin
						next_cur.val_a = reg_rdata;
						next_cur.target_addr = cur.byte2;
					end else begin
						next_cur.val_b = reg_rdata;
						next_cur.target_addr = working_addr(cur.byte1[7:4]);
					end
					next_cur.state = exec_pkg::st_compute;
				end
			end
			exec_pkg::st_vec_high: begin
				next_cur.target[15:8] = prog_rdata; // see RULE8
				next_cur.prog_req.rd = 1'b1;
				next_cur.prog_req.addr = {8'h00, cur.byte1} + 16'd1;
				next_cur.state = exec_pkg::st_vec_low;
			end
			exec_pkg::st_vec_low: begin
				next_cur.target[7:0] = prog_rdata;
				next_cur.state = exec_pkg::st_push_low;
			end
			exec_pkg::st_push_low: begin
				next_cur.sp = cur.sp - 16'd1;
				next_cur.stack_req.wr = 1'b1; // see RULE5
				next_cur.stack_req.addr = cur.sp - 16'd1; // see RULE16
				next_cur.stack_req.wdata = cur.ret_addr[7:0];
				next_cur.state = exec_pkg::st_push_high;
			end
			exec_pkg::st_push_high: begin
				next_cur.sp = cur.sp - 16'd1;
				next_cur.stack_req.wr = 1'b1; // see RULE5
				next_cur.stack_req.addr = cur.sp - 16'd1;
				next_cur.stack_req.wdata = cur.ret_addr[15:8];
				next_cur.pc = cur.target; // see RULE7
				next_cur.state = exec_pkg::st_wait;
			end
			exec_pkg::st_compute: begin
				next_cur.flags = flag_next; // see RULE3 RULE15
				unique case (cur.op)
					exec_pkg::op_bit_xor: begin
						next_cur.reg_req.wr = 1'b1; // see RULE1
						next_cur.reg_req.addr = cur.target_addr; // see RULE2
						next_cur.reg_req.wdata = xor_result;
						next_cur.pc = cur.pc + 16'd3;
					end
					exec_pkg::op_zero_dest_reg: begin
						next_cur.reg_req.wr = 1'b1; // see RULE11
						next_cur.reg_req.addr = cur.target_addr;
						next_cur.reg_req.wdata = 8'h00;
						next_cur.pc = cur.pc + 16'd2;
					end
					exec_pkg::op_complement_reg: begin
						next_cur.reg_req.wr = 1'b1; // see RULE13
						next_cur.reg_req.addr = cur.target_addr;
						next_cur.reg_req.wdata = ~cur.val_a; // see RULE14
						next_cur.pc = cur.pc + 16'd2;
					end
					default: ; // Carry invert: flags only, see RULE9
				endcase
				// Written-back flag byte also updates internal copy
				if (next_cur.reg_req.wr && cur.target_addr == exec_pkg::status_flag_byte_addr) begin
					next_cur.flags = next_cur.reg_req.wdata;
				end
				next_cur.state = exec_pkg::st_wait;
			end
			exec_pkg::st_wait: begin
				if (cur.count >= cur.total) begin
					next_cur.done = 1'b1;
					next_cur.state = exec_pkg::st_idle;
				end
			end
			default: next_cur.state = exec_pkg::st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cur <= '0;
			cur.state <= exec_pkg::st_idle;
			cur.flags <= exec_pkg::status_flag_reset;
			cur.sp <= exec_pkg::stack_pointer_reset;
			cur.pc <= exec_pkg::pc_reset;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_req = cur.reg_req;
	assign prog_req = cur.prog_req;
	assign stack_req = cur.stack_req;
	assign sw_rdata = cur.sw_rdata;
	assign busy = (cur.state != exec_pkg::st_idle);
	assign done = cur.done;
	assign pc = cur.pc;
	assign stack_pointer = cur.sp;

	// Assertions
	property p_carry_toggle;
		@(posedge ref_clk) disable iff (reset)
		(cur.state == exec_pkg::st_compute && cur.op == exec_pkg::op_carry_invert && !sw_write)
		|=> cur.flags[exec_pkg::flag_c] != $past(cur.flags[exec_pkg::flag_c]);
	endproperty
	a_carry_toggle: assert property (p_carry_toggle) else $error("carry not toggled"); // see RULE9

	property p_xor_sign_clear;
		@(posedge ref_clk) disable iff (reset)
		(cur.state == exec_pkg::st_compute && cur.op == exec_pkg::op_bit_xor && !sw_write
			&& cur.target_addr != exec_pkg::status_flag_byte_addr)
		|=> !cur.flags[exec_pkg::flag_s];
	endproperty
	a_xor_sign_clear: assert property (p_xor_sign_clear) else $error("sign not cleared"); // see RULE3

	property p_clear_zero;
		@(posedge ref_clk) disable iff (reset)
		(cur.state == exec_pkg::st_compute && cur.op == exec_pkg::op_zero_dest_reg)
		|=> reg_req.wr && reg_req.wdata == 8'h00;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear wrote nonzero"); // see RULE11

	property p_complement_write;
		@(posedge ref_clk) disable iff (reset)
		(cur.state == exec_pkg::st_compute && cur.op == exec_pkg::op_complement_reg)
		|=> reg_req.wdata == ~$past(cur.val_a);
	endproperty
	a_complement_write: assert property (p_complement_write) else $error("bad complement"); // see RULE13

	sequence s_push_pair;
		stack_req.wr ##1 stack_req.wr;
	endsequence
	property p_push_order;
		@(posedge ref_clk) disable iff (reset)
		(cur.state == exec_pkg::st_push_low) |=> s_push_pair
			and (stack_req.addr == $past(cur.sp) - 16'd1);
	endproperty
	a_push_order: assert property (p_push_order) else $error("push order wrong"); // see RULE5

	property p_call_pc;
		@(posedge ref_clk) disable iff (reset)
		(cur.state == exec_pkg::st_push_high) |=> pc == $past(cur.target) && busy;
	endproperty
	a_call_pc: assert property (p_call_pc) else $error("pc not loaded after push"); // see RULE7

	property p_direct_call_len;
		@(posedge ref_clk) disable iff (reset)
		(start && !busy && opcode == exec_pkg::op_call_direct) |=> ##18 done;
	endproperty
	a_direct_call_len: assert property (p_direct_call_len) else $error("call timing"); // see RULE7

	property p_bit_xor_len;
		@(posedge ref_clk) disable iff (reset)
		(start && !busy && opcode == exec_pkg::op_bit_xor) |=> ##10 done;
	endproperty
	a_bit_xor_len: assert property (p_bit_xor_len) else $error("bit xor timing"); // see RULE4

	property p_short_len;
		@(posedge ref_clk) disable iff (reset)
		(start && !busy && opcode == exec_pkg::op_carry_invert) |=> ##6 done;
	endproperty
	a_short_len: assert property (p_short_len) else $error("short op timing"); // see RULE9
endmodule
`default_nettype wire

// File: tb/exec_partner.sv
// Behavioural register file, program memory and stack memory facing the execution unit.
// Assumes registered one-cycle requests; a read is answered while its request stands.
`timescale 1ns/1ps
`default_nettype none
module exec_partner (
	// Clock
	input wire logic ref_clk,
	// Requests from the unit
	input wire exec_pkg::reg_req_type reg_req,
	input wire exec_pkg::mem_req_type prog_req,
	input wire exec_pkg::mem_req_type stack_req,
	// Read answers
	output logic [7:0] reg_rdata,
	output logic [7:0] prog_rdata
);
	logic [7:0] regs [0:255];
	logic [7:0] prog [0:65535];
	logic [7:0] stack_mem [0:65535];

	// Read data stand with the request; idle lines show the inverse so stale data never passes
	assign reg_rdata = reg_req.rd ? regs[reg_req.addr] : ~regs[reg_req.addr];
	assign prog_rdata = prog_req.rd ? prog[prog_req.addr] : ~prog[prog_req.addr];

	always @(posedge ref_clk) begin
		if (reg_req.wr)
			regs[reg_req.addr] <= reg_req.wdata;
		if (stack_req.wr)
			stack_mem[stack_req.addr] <= stack_req.wdata;
	end
endmodule
`default_nettype wire

// File: tb/bit_xor_call_clear_exec_tb.sv
// Self-checking bench for the execution unit with random and hand-picked instructions.
// Assumes the partner model answers reads while each registered request stands.
`timescale 1ns/1ps
`default_nettype none
module bit_xor_call_clear_exec_tb;
	logic ref_clk;
	logic reset;
	logic start;
	logic [7:0] opcode;
	exec_pkg::reg_req_type reg_req;
	exec_pkg::mem_req_type prog_req;
	exec_pkg::mem_req_type stack_req;
	logic [7:0] reg_rdata, prog_rdata, sw_addr, sw_wdata, sw_rdata, got;
	logic sw_write, sw_read, busy, done;
	logic [15:0] pc, stack_pointer;
	logic [15:0] exp_pc = 16'h0000;
	logic [15:0] exp_sp = 16'h0000;
	logic [31:0] rng = 32'h4;
	int num_errors = 0;
	int checked = 0;

	exec_core exec_core_inst (.ref_clk(ref_clk), .reset(reset), .start(start), .opcode(opcode),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .prog_req(prog_req), .stack_req(stack_req),
		.prog_rdata(prog_rdata), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
		.sw_read(sw_read), .sw_rdata(sw_rdata), .busy(busy), .done(done), .pc(pc),
		.stack_pointer(stack_pointer));
	exec_partner exec_partner_inst (.ref_clk(ref_clk), .reg_req(reg_req), .prog_req(prog_req),
		.stack_req(stack_req), .reg_rdata(reg_rdata), .prog_rdata(prog_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [7:0] zs_flags(input logic [7:0] old, input logic [7:0] res,
			input logic s, input logic clr_v);
		logic [7:0] f;
		f = old;
		f[exec_pkg::flag_z] = (res == 8'h00);
		f[exec_pkg::flag_s] = s;
		if (clr_v)
			f[exec_pkg::flag_v] = 1'b0;
		return f;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sw_write <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge ref_clk);
		sw_write <= 1'b0;
	endtask

	task automatic sw_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		sw_read <= 1'b1;
		sw_addr <= a;
		@(posedge ref_clk);
		sw_read <= 1'b0;
		#1 d = sw_rdata;
	endtask

	// Places the instruction at the expected pc, starts it and counts edges up to done
	task automatic run_op(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
			input logic [4:0] cyc, input bit poke);
		int n;
		exec_partner_inst.prog[exp_pc] = op;
		exec_partner_inst.prog[exp_pc + 16'h1] = b1;
		exec_partner_inst.prog[exp_pc + 16'h2] = b2;
		@(posedge ref_clk);
		start <= 1'b1;
		opcode <= op;
		@(posedge ref_clk);
		start <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			if (poke && n == 2)
				start <= 1'b1;
			if (poke && n == 3)
				start <= 1'b0;
			#1;
		end while (done !== 1'b1 && n < 40);
		check(16'(n), {11'h000, cyc});
		@(posedge ref_clk);
		#1 check({15'h0000, done}, 16'h0000);
	endtask

	task automatic exec_one(input int k, input bit poke);
		logic [7:0] fl, efl, p, q, w, x, res, b1, b2, op, wa, rd;
		logic [15:0] tgt, ret;
		logic [4:0] cyc;
		logic [1:0] len;
		logic [31:0] r;
		r = rnd();
		fl = r[7:0];
		p = {1'b0, r[14:8]};
		q = {1'b0, r[22:16]};
		if (q == p)
			q = q ^ 8'h01;
		w = r[31:24];
		r = rnd();
		x = r[7:0];
		tgt = {2'b10, r[21:8]};
		b1 = p;
		b2 = 8'h00;
		len = 2'd2;
		cyc = exec_pkg::cycles_short;
		op = 8'h00;
		efl = fl;
		res = 8'h00;
		wa = {exec_pkg::working_bank, r[27:24]};
		sw_wr(exec_pkg::status_flag_byte_addr, fl);
		case (k)
		0: begin
			op = exec_pkg::op_carry_invert;
			len = 2'd1;
			efl[exec_pkg::flag_c] = ~fl[exec_pkg::flag_c];
		end
		1, 2, 3, 4: begin
			op = (k < 3) ? exec_pkg::op_zero_dest_reg : exec_pkg::op_complement_reg;
			op[0] = (k % 2 == 0);
			if (k > 2 && r[31])
				w = 8'hff;
			exec_partner_inst.regs[p] = (k % 2 == 0) ? q : w;
			if (k % 2 == 0)
				exec_partner_inst.regs[q] = w;
			res = (k < 3) ? 8'h00 : ~w;
			if (k > 2)
				efl = zs_flags(fl, res, res[7], 1'b1);
		end
		5: begin
			op = exec_pkg::op_bit_xor;
			b1 = {r[27:24], r[30:28], r[31]};
			b2 = p;
			len = 2'd3;
			cyc = exec_pkg::cycles_bit_xor;
			if (r[23]) begin
				w = 8'h00;
				x = 8'h00;
			end
			exec_partner_inst.regs[wa] = w;
			exec_partner_inst.regs[p] = x;
			res = b1[0] ? x : w;
			if (b1[0])
				res[b1[3:1]] = x[b1[3:1]] ^ w[0];
			else
				res[0] = w[0] ^ x[b1[3:1]];
			efl = zs_flags(fl, res, 1'b0, 1'b0);
		end
		6, 7, 8: begin
			op = (k == 6) ? exec_pkg::op_call_direct :
				(k == 7) ? exec_pkg::op_call_pair : exec_pkg::op_call_vector;
			b1 = (k == 6) ? tgt[15:8] : ((k == 7) ? {p[7:1], 1'b0} : p);
			b2 = tgt[7:0];
			len = (k == 6) ? 2'd3 : 2'd2;
			cyc = (k == 8) ? exec_pkg::cycles_call_vector : exec_pkg::cycles_call_direct;
			if (k == 7) begin
				exec_partner_inst.regs[b1] = tgt[15:8];
				exec_partner_inst.regs[b1 + 8'h01] = tgt[7:0];
			end
			if (k == 8) begin
				exec_partner_inst.prog[{8'h00, b1}] = tgt[15:8];
				exec_partner_inst.prog[{8'h00, b1} + 16'h1] = tgt[7:0];
			end
		end
		default: len = 2'd0;
		endcase
		run_op(op, b1, b2, cyc, poke);
		ret = exp_pc + {14'h0000, len};
		if (k >= 1 && k <= 4) begin
			check(exec_partner_inst.regs[(k % 2 == 0) ? q : p], res);
			if (k % 2 == 0)
				check(exec_partner_inst.regs[p], q);
		end
		if (k == 5) begin
			rd = b1[0] ? exec_partner_inst.regs[wa] : exec_partner_inst.regs[p];
			check(b1[0] ? exec_partner_inst.regs[p] : exec_partner_inst.regs[wa], res);
			check(rd, b1[0] ? w : x);
		end
		if (k >= 6 && k <= 8) begin
			check(exec_partner_inst.stack_mem[exp_sp - 16'h1], ret[7:0]);
			check(exec_partner_inst.stack_mem[exp_sp - 16'h2], ret[15:8]);
			exp_sp = exp_sp - 16'h2;
			ret = tgt;
		end
		exp_pc = ret;
		check(pc, exp_pc);
		check(stack_pointer, exp_sp);
		sw_rd(exec_pkg::status_flag_byte_addr, got);
		check(got, efl);
	endtask

	initial begin
		#500000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		reset = 1'b1;
		start = 1'b0;
		opcode = 8'h00;
		sw_addr = 8'h00;
		sw_wdata = 8'h00;
		sw_write = 1'b0;
		sw_read = 1'b0;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1 check(pc, exec_pkg::pc_reset);
		check(stack_pointer, exec_pkg::stack_pointer_reset);
		check({14'h0000, busy, done}, 16'h0000);
		check(sw_rdata, 8'h00);
		sw_rd(exec_pkg::status_flag_byte_addr, got);
		check(got, exec_pkg::status_flag_reset);
		sw_wr(8'h10, 8'h5a);
		sw_rd(8'h10, got);
		check(got, 8'h00);
		sw_rd(exec_pkg::status_flag_byte_addr, got);
		check(got, exec_pkg::status_flag_reset);
		// First a direct call moves execution clear of the vector table
		exec_one(6, 1'b0);
		// Every opcode and the unknown one, with a start pulse while busy
		for (int k = 0; k < 10; k++)
			exec_one(k, 1'b1);
		repeat (60)
			exec_one(int'(rnd() % 10), 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire
